// ---- dkexp_defs.svh ----
`ifndef DKEXP_DEFS_SVH
`define DKEXP_DEFS_SVH

// ****************************************************************
// Register indices on the serial register interface.
// ****************************************************************
`define DKEXP_IDX_PRIMARY_STATUS_REG 8'h02
`define DKEXP_IDX_SETUP0 8'h10
`define DKEXP_IDX_MODE_SEL 8'h18
`define DKEXP_IDX_FINE_HI 8'h20
`define DKEXP_IDX_FINE_LO 8'h21
`define DKEXP_IDX_COARSE_HI 8'h22
`define DKEXP_IDX_COARSE_LO 8'h23
`define DKEXP_IDX_GAIN 8'h24
`define DKEXP_IDX_CLKDIV 8'h25
`define DKEXP_IDX_BLACK_EXT 8'h29
`define DKEXP_IDX_BLACK_SETUP 8'h2A
`define DKEXP_IDX_DARK_EXT 8'h2D
`define DKEXP_IDX_DARK_SETUP 8'h2E
`define DKEXP_IDX_LINE_HI 8'h52
`define DKEXP_IDX_LINE_LO 8'h53
`define DKEXP_IDX_FIELD_HI 8'h61
`define DKEXP_IDX_FIELD_LO 8'h62

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define DKEXP_DS_HALF 2
`define DKEXP_DS_WIDE 5
`define DKEXP_MS_IGAIN_DIRECT 1
`define DKEXP_ST_FINE 0
`define DKEXP_ST_COARSE 1
`define DKEXP_ST_CLKDIV 2
`define DKEXP_ST_GAIN 3
`define DKEXP_ST_TIMING 6
`define DKEXP_RST_GAIN 8'hF0
`define DKEXP_RST_DARK_SETUP 8'h09
`define DKEXP_RST_BLACK_SETUP 8'h09
`define DKEXP_RST_SETUP0 8'h02
`define DKEXP_RST_LINE 16'h01A0
`define DKEXP_RST_FIELD 16'h0138

// ****************************************************************
// Levels and timing counts.
// ****************************************************************
`define DKEXP_DARK_TARGET_INT 12'sh080
`define DKEXP_BAND_NARROW 12'sh002
`define DKEXP_BAND_WIDE 12'sh004
`define DKEXP_COARSE_MARGIN 16'h0001
`define DKEXP_FINE_OFS_NTSC_CIF 16'h0033
`define DKEXP_FINE_OFS_PAL 16'h0056
`define DKEXP_FINE_OFS_QCIF 16'h0017
`define DKEXP_FRAC_BITS 4

`endif

// ---- dkexp_pkg.sv ----
package dkexp_pkg;

  // Video format, held in the low two bits of the setup register.
  typedef enum logic [1:0] {
    DKEXP_VM_PAL,
    DKEXP_VM_NTSC,
    DKEXP_VM_CIF,
    DKEXP_VM_QCIF
  } dkexp_vmode_t;

  // Offset cancellation source, low two bits of the black and dark setup registers.
  typedef enum logic [1:0] {
    DKEXP_OFS_NONE,
    DKEXP_OFS_INTERNAL,
    DKEXP_OFS_EXTERNAL,
    DKEXP_OFS_RSVD
  } dkexp_ofs_mode_t;

endpackage : dkexp_pkg

// ---- dkexp_ctrl.sv ----
`timescale 1ns/1ps
`include "dkexp_defs.svh"
// Contract
// - Shielded dark pixels output 128 inside, 64 outside.
// - Dark offset uses leaky integrator on corrected data.
// - Dark target 64, cancellation defaults to zero.
// - Dark setup index 46, bit2 halves lines.
// - Half mode uses only lines following dark.
// - Black and dark offset modes chosen independently.
// - Exposure is coarse times line plus fine, scaled.
// - Divider ratio is basic times optional divisor.
// - Coarse maximum is field length minus one.
// - Fine maximum is line length minus mode offset.
// - Requests above maximum are clipped to it.
// - Gain index 36: capacitive high, current low.
// - Direct mode: current code is inverted nibble.
// - Otherwise current code is inverted mirrored nibble.
// - Ten-bit mode: capacitive code nibble then 11.
// - Nine-bit mode: halved nibble then 11.
// - PAL/NTSC run nine bits, CIF/QCIF ten.
// - Gain applies about one frame after exposure.
// - Writes held as shadows, pending flags shown.
module dkexp_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_index,
  input wire logic [7:0] reg_wr_data,
  input wire logic msg_busy,
  output logic [7:0] reg_rd_data,
  input wire logic field_odd,
  input wire logic evt_odd_to_even,
  input wire logic evt_eof_sav,
  input wire logic evt_first_dark_sav,
  input wire logic line_start,
  input wire logic dark_line,
  input wire logic pix_valid,
  input wire logic [9:0] pix_data,
  input wire logic [9:0] black_int_offset,
  output logic [7:0] pix_out,
  output logic [9:0] black_offset,
  output logic [9:0] dark_offset,
  output logic pix_en,
  output logic adc_10bit,
  output logic [3:0] igain,
  output logic [5:0] cgain,
  output logic [8:0] gain_q4,
  output logic [15:0] coarse_applied,
  output logic [15:0] fine_applied,
  output logic [39:0] exp_period_clk
);

  // ****************************************************************
  // Decode helpers.
  // ****************************************************************
  function automatic logic [15:0] fine_ofs(input dkexp_pkg::dkexp_vmode_t m);
    unique case (m)
      dkexp_pkg::DKEXP_VM_PAL: fine_ofs = `DKEXP_FINE_OFS_PAL;
      dkexp_pkg::DKEXP_VM_QCIF: fine_ofs = `DKEXP_FINE_OFS_QCIF;
      dkexp_pkg::DKEXP_VM_NTSC, dkexp_pkg::DKEXP_VM_CIF: fine_ofs = `DKEXP_FINE_OFS_NTSC_CIF;
    endcase
  endfunction : fine_ofs

  function automatic logic [15:0] clip(input logic [15:0] req, input logic [15:0] lim);
    clip = (req > lim) ? lim : req;
  endfunction : clip

  function automatic logic [9:0] pick_ofs(input logic [1:0] mode, input logic [9:0] int_v,
                                          input logic [7:0] ext_v);
    unique case (dkexp_pkg::dkexp_ofs_mode_t'(mode))
      dkexp_pkg::DKEXP_OFS_INTERNAL: pick_ofs = int_v;
      dkexp_pkg::DKEXP_OFS_EXTERNAL: pick_ofs = {2'b00, ext_v};
      default: pick_ofs = 10'h000;
    endcase
  endfunction : pick_ofs

  // ****************************************************************
  // Shadow and working registers.
  // ****************************************************************
  logic [7:0] sh_setup0_r, sh_mode_r, sh_gain_r, sh_clkdiv_r, sh_bext_r, sh_bset_r;
  logic [7:0] sh_dext_r, sh_dset_r;
  logic [15:0] sh_fine_r, sh_coarse_r, sh_line_r, sh_field_r;
  logic [7:0] wk_setup0_r, wk_mode_r, wk_gain_r, wk_clkdiv_r, wk_bext_r, wk_bset_r;
  logic [7:0] wk_dext_r, wk_dset_r;
  logic [15:0] wk_fine_r, wk_coarse_r, wk_line_r, wk_field_r;
  logic pend_fine_r, pend_coarse_r, pend_clk_r, pend_gain_r, pend_tim_r, gain_arm_r;
  logic [7:0] sh_setup0_nxt, sh_mode_nxt, sh_gain_nxt, sh_clkdiv_nxt, sh_bext_nxt, sh_bset_nxt;
  logic [7:0] sh_dext_nxt, sh_dset_nxt;
  logic [15:0] sh_fine_nxt, sh_coarse_nxt, sh_line_nxt, sh_field_nxt;
  logic pend_fine_nxt, pend_coarse_nxt, pend_clk_nxt, pend_gain_nxt, pend_tim_nxt, gain_arm_nxt;
  logic wr_fine, wr_coarse, wr_gain, wr_clk, wr_tim;
  logic upd_tim, upd_fine, upd_coarse, upd_gain;
  dkexp_pkg::dkexp_vmode_t vmode;

  assign vmode = dkexp_pkg::dkexp_vmode_t'(wk_setup0_r[1:0]);
  assign upd_tim = evt_odd_to_even;
  // Fine exposure follows a pending line length so both land together.
  assign upd_fine = pend_tim_r ? evt_odd_to_even : (evt_eof_sav && field_odd);
  assign upd_coarse = evt_first_dark_sav && field_odd;
  // Gain waits one frame behind exposure and never lands mid-message.
  assign upd_gain = evt_first_dark_sav && field_odd && gain_arm_r && !msg_busy;

  // Shadow capture and pending flags; a write in the consume cycle keeps its flag.
  always_comb begin
    sh_setup0_nxt = sh_setup0_r;
    sh_mode_nxt = sh_mode_r;
    sh_gain_nxt = sh_gain_r;
    sh_clkdiv_nxt = sh_clkdiv_r;
    sh_bext_nxt = sh_bext_r;
    sh_bset_nxt = sh_bset_r;
    sh_dext_nxt = sh_dext_r;
    sh_dset_nxt = sh_dset_r;
    sh_fine_nxt = sh_fine_r;
    sh_coarse_nxt = sh_coarse_r;
    sh_line_nxt = sh_line_r;
    sh_field_nxt = sh_field_r;
    wr_fine = 1'b0;
    wr_coarse = 1'b0;
    wr_gain = 1'b0;
    wr_clk = 1'b0;
    wr_tim = 1'b0;
    if (reg_wr_en) begin
      unique case (reg_index)
        `DKEXP_IDX_SETUP0: begin sh_setup0_nxt = reg_wr_data; wr_tim = 1'b1; end
        `DKEXP_IDX_MODE_SEL: begin sh_mode_nxt = reg_wr_data; wr_tim = 1'b1; end
        `DKEXP_IDX_GAIN: begin sh_gain_nxt = reg_wr_data; wr_gain = 1'b1; end
        `DKEXP_IDX_CLKDIV: begin sh_clkdiv_nxt = {4'h0, reg_wr_data[3:0]}; wr_clk = 1'b1; end
        `DKEXP_IDX_BLACK_EXT: begin sh_bext_nxt = reg_wr_data; wr_tim = 1'b1; end
        `DKEXP_IDX_BLACK_SETUP: begin sh_bset_nxt = reg_wr_data; wr_tim = 1'b1; end
        `DKEXP_IDX_DARK_EXT: begin sh_dext_nxt = reg_wr_data; wr_tim = 1'b1; end
        `DKEXP_IDX_DARK_SETUP: begin sh_dset_nxt = reg_wr_data; wr_tim = 1'b1; end
        `DKEXP_IDX_FINE_HI: begin sh_fine_nxt[15:8] = reg_wr_data; wr_fine = 1'b1; end
        `DKEXP_IDX_FINE_LO: begin sh_fine_nxt[7:0] = reg_wr_data; wr_fine = 1'b1; end
        `DKEXP_IDX_COARSE_HI: begin sh_coarse_nxt[15:8] = reg_wr_data; wr_coarse = 1'b1; end
        `DKEXP_IDX_COARSE_LO: begin sh_coarse_nxt[7:0] = reg_wr_data; wr_coarse = 1'b1; end
        `DKEXP_IDX_LINE_HI: begin sh_line_nxt[15:8] = reg_wr_data; wr_tim = 1'b1; end
        `DKEXP_IDX_LINE_LO: begin sh_line_nxt[7:0] = reg_wr_data; wr_tim = 1'b1; end
        `DKEXP_IDX_FIELD_HI: begin sh_field_nxt[15:8] = reg_wr_data; wr_tim = 1'b1; end
        `DKEXP_IDX_FIELD_LO: begin sh_field_nxt[7:0] = reg_wr_data; wr_tim = 1'b1; end
        default: ;
      endcase
    end
    pend_fine_nxt = wr_fine | (pend_fine_r & ~upd_fine);
    pend_coarse_nxt = wr_coarse | (pend_coarse_r & ~upd_coarse);
    pend_clk_nxt = wr_clk | (pend_clk_r & ~upd_tim);
    pend_gain_nxt = wr_gain | (pend_gain_r & ~upd_gain);
    pend_tim_nxt = wr_tim | (pend_tim_r & ~upd_tim);
    gain_arm_nxt = gain_arm_r;
    if (upd_gain) begin
      gain_arm_nxt = 1'b0;
    end else if (upd_coarse && pend_gain_r) begin
      gain_arm_nxt = 1'b1;
    end
  end

  // Shadow, working and flag registers; working copies load on their update points.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sh_setup0_r <= `DKEXP_RST_SETUP0;
      sh_mode_r <= 8'h00;
      sh_gain_r <= `DKEXP_RST_GAIN;
      sh_clkdiv_r <= 8'h00;
      sh_bext_r <= 8'h00;
      sh_bset_r <= `DKEXP_RST_BLACK_SETUP;
      sh_dext_r <= 8'h00;
      sh_dset_r <= `DKEXP_RST_DARK_SETUP;
      sh_fine_r <= 16'h0000;
      sh_coarse_r <= 16'h0000;
      sh_line_r <= `DKEXP_RST_LINE;
      sh_field_r <= `DKEXP_RST_FIELD;
      wk_setup0_r <= `DKEXP_RST_SETUP0;
      wk_mode_r <= 8'h00;
      wk_gain_r <= `DKEXP_RST_GAIN;
      wk_clkdiv_r <= 8'h00;
      wk_bext_r <= 8'h00;
      wk_bset_r <= `DKEXP_RST_BLACK_SETUP;
      wk_dext_r <= 8'h00;
      wk_dset_r <= `DKEXP_RST_DARK_SETUP;
      wk_fine_r <= 16'h0000;
      wk_coarse_r <= 16'h0000;
      wk_line_r <= `DKEXP_RST_LINE;
      wk_field_r <= `DKEXP_RST_FIELD;
      pend_fine_r <= 1'b0;
      pend_coarse_r <= 1'b0;
      pend_clk_r <= 1'b0;
      pend_gain_r <= 1'b0;
      pend_tim_r <= 1'b0;
      gain_arm_r <= 1'b0;
    end else begin
      sh_setup0_r <= sh_setup0_nxt;
      sh_mode_r <= sh_mode_nxt;
      sh_gain_r <= sh_gain_nxt;
      sh_clkdiv_r <= sh_clkdiv_nxt;
      sh_bext_r <= sh_bext_nxt;
      sh_bset_r <= sh_bset_nxt;
      sh_dext_r <= sh_dext_nxt;
      sh_dset_r <= sh_dset_nxt;
      sh_fine_r <= sh_fine_nxt;
      sh_coarse_r <= sh_coarse_nxt;
      sh_line_r <= sh_line_nxt;
      sh_field_r <= sh_field_nxt;
      if (upd_tim) begin
        wk_setup0_r <= sh_setup0_r;
        wk_mode_r <= sh_mode_r;
        wk_clkdiv_r <= sh_clkdiv_r;
        wk_bext_r <= sh_bext_r;
        wk_bset_r <= sh_bset_r;
        wk_dext_r <= sh_dext_r;
        wk_dset_r <= sh_dset_r;
        wk_line_r <= sh_line_r;
        wk_field_r <= sh_field_r;
      end
      if (upd_fine) wk_fine_r <= sh_fine_r;
      if (upd_coarse) wk_coarse_r <= sh_coarse_r;
      if (upd_gain) wk_gain_r <= sh_gain_r;
      pend_fine_r <= pend_fine_nxt;
      pend_coarse_r <= pend_coarse_nxt;
      pend_clk_r <= pend_clk_nxt;
      pend_gain_r <= pend_gain_nxt;
      pend_tim_r <= pend_tim_nxt;
      gain_arm_r <= gain_arm_nxt;
    end
  end

  // ****************************************************************
  // Exposure limits, divider and period.
  // ****************************************************************
  logic [6:0] div_total, div_cnt_r, div_cnt_nxt;
  logic [3:0] div_basic;
  logic [3:0] div_code;
  logic [3:0] div_opt;
  logic [15:0] coarse_max, fine_max;
  logic [39:0] exp_nxt;

  // Basic division comes from the video mode; a zero optional divisor counts as one.
  // The mode code shown in the divisor readback follows the same decode.
  always_comb begin
    unique case (vmode)
      dkexp_pkg::DKEXP_VM_CIF: begin
        div_basic = 4'h4;
        div_code = 4'h1;
      end
      dkexp_pkg::DKEXP_VM_QCIF: begin
        div_basic = 4'h8;
        div_code = 4'h3;
      end
      dkexp_pkg::DKEXP_VM_PAL, dkexp_pkg::DKEXP_VM_NTSC: begin
        div_basic = 4'h2;
        div_code = 4'h0;
      end
    endcase
    div_opt = (wk_clkdiv_r[3:0] == 4'h0) ? 4'h1 : wk_clkdiv_r[3:0];
    div_total = 7'(div_basic) * 7'(div_opt);
    div_cnt_nxt = (div_cnt_r + 7'h01 >= div_total) ? 7'h00 : div_cnt_r + 7'h01;
    coarse_max = wk_field_r - `DKEXP_COARSE_MARGIN;
    fine_max = wk_line_r - fine_ofs(vmode);
    coarse_applied = clip(wk_coarse_r, coarse_max);
    fine_applied = clip(wk_fine_r, fine_max);
    exp_nxt = (40'(coarse_applied) * 40'(wk_line_r) + 40'(fine_applied)) * 40'(div_total);
  end

  assign pix_en = (div_cnt_r == 7'h00);

  // Divider counter and registered exposure period in input clock periods.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_cnt_r <= 7'h00;
      exp_period_clk <= 40'h0000000000;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      exp_period_clk <= exp_nxt;
    end
  end

  // ****************************************************************
  // Gain decode.
  // ****************************************************************
  // Mirror-inverse is the default wiring; the direct option drops the mirror.
  always_comb begin
    if (wk_mode_r[`DKEXP_MS_IGAIN_DIRECT]) begin
      igain = ~wk_gain_r[3:0];
    end else begin
      igain = ~{wk_gain_r[0], wk_gain_r[1], wk_gain_r[2], wk_gain_r[3]};
    end
    adc_10bit = (vmode == dkexp_pkg::DKEXP_VM_CIF) || (vmode == dkexp_pkg::DKEXP_VM_QCIF);
    cgain = adc_10bit ? {wk_gain_r[7:4], 2'b11} : {1'b0, wk_gain_r[7:5], 2'b11};
    gain_q4 = 9'(9'h100 / (9'(igain) + 9'h001));
  end

  // ****************************************************************
  // Dark offset integrator and output path.
  // ****************************************************************
  logic prev_dark_r, prev_dark_nxt, half_tog_r, half_tog_nxt, line_use_r, line_use_nxt;
  logic signed [17:0] dacc_r, dacc_nxt;
  logic signed [11:0] corr, err, band;
  logic [7:0] pix_out_nxt;
  logic [9:0] dark_int;

  assign dark_int = dacc_r[`DKEXP_FRAC_BITS +: 10];
  assign dark_offset = pick_ofs(wk_dset_r[1:0], dark_int, wk_dext_r);
  assign black_offset = pick_ofs(wk_bset_r[1:0], black_int_offset, wk_bext_r);

  // Line selection and leaky integration toward the dark target.
  always_comb begin
    prev_dark_nxt = prev_dark_r;
    half_tog_nxt = half_tog_r;
    line_use_nxt = line_use_r;
    if (line_start) begin
      prev_dark_nxt = dark_line;
      half_tog_nxt = (dark_line && prev_dark_r) ? ~half_tog_r : 1'b0;
      // Half mode takes every second dark line, never the first after the shield edge.
      line_use_nxt = dark_line && (!wk_dset_r[`DKEXP_DS_HALF] || (prev_dark_r && !half_tog_r));
    end
    corr = 12'($signed({2'b00, pix_data}) - $signed({2'b00, dark_offset}));
    err = corr - `DKEXP_DARK_TARGET_INT;
    band = wk_dset_r[`DKEXP_DS_WIDE] ? `DKEXP_BAND_WIDE : `DKEXP_BAND_NARROW;
    dacc_nxt = dacc_r;
    if (pix_valid && line_use_r && (err > band || err < -band) &&
        dkexp_pkg::dkexp_ofs_mode_t'(wk_dset_r[1:0]) == dkexp_pkg::DKEXP_OFS_INTERNAL) begin
      dacc_nxt = dacc_r + ((18'(err) <<< `DKEXP_FRAC_BITS) >>> wk_dset_r[4:3]);
    end
    if (corr < 12'sh000) begin
      pix_out_nxt = 8'h00;
    end else if (corr > 12'sh1FF) begin
      pix_out_nxt = 8'hFF;
    end else begin
      pix_out_nxt = corr[8:1];
    end
  end

  // Integrator starts at zero so an ideal dark line needs no correction.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_dark_r <= 1'b0;
      half_tog_r <= 1'b0;
      line_use_r <= 1'b0;
      dacc_r <= 18'sh00000;
      pix_out <= 8'h00;
    end else begin
      prev_dark_r <= prev_dark_nxt;
      half_tog_r <= half_tog_nxt;
      line_use_r <= line_use_nxt;
      dacc_r <= dacc_nxt;
      pix_out <= pix_valid ? pix_out_nxt : pix_out;
    end
  end

  // Register readback, one cycle after the index is presented.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rd_data <= 8'h00;
    end else begin
      unique case (reg_index)
        `DKEXP_IDX_PRIMARY_STATUS_REG: reg_rd_data <= {1'b0, pend_tim_r, 2'b00, pend_gain_r, pend_clk_r,
                                            pend_coarse_r, pend_fine_r};
        `DKEXP_IDX_GAIN: reg_rd_data <= sh_gain_r;
        `DKEXP_IDX_CLKDIV: reg_rd_data <= {div_code, sh_clkdiv_r[3:0]};
        `DKEXP_IDX_DARK_SETUP: reg_rd_data <= sh_dset_r;
        `DKEXP_IDX_BLACK_SETUP: reg_rd_data <= sh_bset_r;
        `DKEXP_IDX_SETUP0: reg_rd_data <= sh_setup0_r;
        `DKEXP_IDX_MODE_SEL: reg_rd_data <= sh_mode_r;
        default: reg_rd_data <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  property p_fine_clip;
    @(posedge clk) disable iff (sys_rst) fine_applied <= wk_line_r - fine_ofs(vmode);
  endproperty
  a_fine_clip: assert property (p_fine_clip) else $error("fine above max");
  property p_coarse_clip;
    @(posedge clk) disable iff (sys_rst)
      (wk_coarse_r >= wk_field_r) |-> coarse_applied == wk_field_r - 16'h0001;
  endproperty
  a_coarse_clip: assert property (p_coarse_clip) else $error("coarse not clipped");
  property p_igain_mirror;
    @(posedge clk) disable iff (sys_rst)
      !wk_mode_r[1] |-> igain[3] == ~wk_gain_r[0] && igain[0] == ~wk_gain_r[3];
  endproperty
  a_igain_mirror: assert property (p_igain_mirror) else $error("igain mirror wrong");
  property p_cgain_9bit;
    @(posedge clk) disable iff (sys_rst)
      (!adc_10bit && wk_gain_r[7:4] == 4'hF) |-> cgain == 6'h1F;
  endproperty
  a_cgain_9bit: assert property (p_cgain_9bit) else $error("cgain 9bit wrong");
  property p_pend_set;
    @(posedge clk) disable iff (sys_rst)
      (reg_wr_en && reg_index == `DKEXP_IDX_GAIN) |=> pend_gain_r;
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("gain pending lost");
  property p_gain_after_exp;
    @(posedge clk) disable iff (sys_rst) $changed(wk_gain_r) |-> $past(gain_arm_r);
  endproperty
  a_gain_after_exp: assert property (p_gain_after_exp) else $error("gain early");
  property p_coarse_point;
    @(posedge clk) disable iff (sys_rst) $changed(wk_coarse_r) |-> $past(upd_coarse);
  endproperty
  a_coarse_point: assert property (p_coarse_point) else $error("coarse off point");
  property p_none_zero;
    @(posedge clk) disable iff (sys_rst) (wk_dset_r[1:0] == 2'b00) |-> dark_offset == 10'h000;
  endproperty
  a_none_zero: assert property (p_none_zero) else $error("dark none nonzero");
  property p_adc_mode;
    @(posedge clk) disable iff (sys_rst) (vmode == dkexp_pkg::DKEXP_VM_PAL) |-> !adc_10bit;
  endproperty
  a_adc_mode: assert property (p_adc_mode) else $error("PAL not 9bit");
  c_gain_apply: cover property (@(posedge clk) disable iff (sys_rst) upd_gain);
  c_fine_clip: cover property (@(posedge clk) disable iff (sys_rst) wk_fine_r > fine_max);
  c_dark_step: cover property (@(posedge clk) disable iff (sys_rst) dacc_nxt != dacc_r);

endmodule : dkexp_ctrl

// ---- dkexp_host.sv ----
`timescale 1ns/1ps
`include "dkexp_defs.svh"
// *****
// Controller on the far side of the register interface.
// *****
module dkexp_host (
  input wire logic clk,
  input wire logic [7:0] reg_rd_data,
  output logic reg_wr_en,
  output logic [7:0] reg_index,
  output logic [7:0] reg_wr_data
);
  // Quiet bus until the first request.
  initial begin
    reg_wr_en = 1'b0;
    reg_index = 8'h00;
    reg_wr_data = 8'h00;
  end

  // One byte write; gain bytes are screened as a careful controller would.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (idx == `DKEXP_IDX_GAIN) begin
      v[7:4] = 4'hF;
      if (v[3:0] > 4'hC) v[3:0] = 4'hC;
    end
    @(posedge clk);
    #1;
    reg_wr_en = 1'b1;
    reg_index = idx;
    reg_wr_data = v;
    @(posedge clk);
    #1;
    reg_wr_en = 1'b0;
    reg_wr_data = ~v; // Released data must not look like the last byte.
  endtask : wr

  // Readback is registered, so one edge passes before the byte is taken.
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_index = idx;
    @(posedge clk);
    #1;
    d = reg_rd_data;
  endtask : rd
endmodule : dkexp_host

// ---- dark_offset_exposure_gain_ctrl_tb.sv ----
`timescale 1ns/1ps
`include "dkexp_defs.svh"
module dark_offset_exposure_gain_ctrl_tb;
  // *****
  // Bench signals, clock and hookup.
  // *****
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic field_odd = 1'b0;
  logic ev_oe = 1'b0;
  logic ev_eof = 1'b0;
  logic ev_dk = 1'b0;
  logic pix_valid = 1'b0;
  logic [9:0] pix_data = 10'h000;
  logic [9:0] blk_int = 10'h05A;
  logic ln_start = 1'b0;
  logic ln_dark = 1'b0;
  logic busy = 1'b0;
  logic pix_en;
  logic wr_en;
  logic [7:0] idx, wd, rd, pix_out;
  logic [9:0] black_offset, dark_offset;
  logic adc_10bit;
  logic [3:0] igain;
  logic [5:0] cgain;
  logic [8:0] gain_q4;
  logic [15:0] coarse_applied, fine_applied;
  logic [39:0] exp_period_clk;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  dkexp_ctrl dut (.clk(clk), .sys_rst(sys_rst), .reg_wr_en(wr_en), .reg_index(idx),
    .reg_wr_data(wd), .msg_busy(busy), .reg_rd_data(rd), .field_odd(field_odd),
    .evt_odd_to_even(ev_oe), .evt_eof_sav(ev_eof), .evt_first_dark_sav(ev_dk),
    .line_start(ln_start), .dark_line(ln_dark), .pix_valid(pix_valid), .pix_data(pix_data),
    .black_int_offset(blk_int), .pix_out(pix_out), .black_offset(black_offset),
    .dark_offset(dark_offset), .pix_en(pix_en), .adc_10bit(adc_10bit), .igain(igain),
    .cgain(cgain), .gain_q4(gain_q4), .coarse_applied(coarse_applied),
    .fine_applied(fine_applied), .exp_period_clk(exp_period_clk));
  dkexp_host host (.clk(clk), .reg_rd_data(rd), .reg_wr_en(wr_en), .reg_index(idx),
    .reg_wr_data(wd));

  // *****
  // Shared tasks.
  // *****
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // One short frame: odd dark start, odd end of frame, then the field flip.
  task automatic frame();
    @(posedge clk);
    #1;
    field_odd = 1'b1;
    ev_dk = 1'b1;
    @(posedge clk);
    #1;
    ev_dk = 1'b0;
    ev_eof = 1'b1;
    @(posedge clk);
    #1;
    ev_eof = 1'b0;
    field_odd = 1'b0;
    ev_oe = 1'b1;
    @(posedge clk);
    #1;
    ev_oe = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : frame

  task automatic end_of_test();
    $display("Checks made %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // *****
  // Scenarios.
  // *****
  task automatic t_rst();
    chk(igain, 4'hF);
    chk(cgain, 6'h3F);
    chk(adc_10bit, 1'b1);
    chk(gain_q4, 9'h010);
    chk(dark_offset, 10'h000);
  endtask : t_rst

  // Requests far above the limits in every video mode, then an in-range pair.
  task automatic t_exp();
    int ofs [4] = '{86, 51, 51, 23};
    int dv [4] = '{2, 2, 4, 8};
    int cd [4] = '{8'h01, 8'h01, 8'h11, 8'h31};
    logic [7:0] s;
    int n = 0;
    host.wr(`DKEXP_IDX_CLKDIV, 8'h01);
    host.wr(`DKEXP_IDX_LINE_HI, 8'h01);
    host.wr(`DKEXP_IDX_LINE_LO, 8'h00);
    host.wr(`DKEXP_IDX_FIELD_HI, 8'h00);
    host.wr(`DKEXP_IDX_FIELD_LO, 8'h40);
    for (int vm = 0; vm < 4; vm++) begin
      host.wr(`DKEXP_IDX_SETUP0, 8'(vm));
      host.wr(`DKEXP_IDX_COARSE_HI, 8'h10);
      host.wr(`DKEXP_IDX_FINE_HI, 8'hFF);
      host.wr(`DKEXP_IDX_FINE_LO, 8'hFF);
      frame();
      frame();
      chk(coarse_applied, 63);
      chk(fine_applied, 256 - ofs[vm]);
      chk(exp_period_clk, (63 * 256 + 256 - ofs[vm]) * dv[vm]);
      host.rd(`DKEXP_IDX_CLKDIV, s);
      chk(s, cd[vm]);
    end
    host.wr(`DKEXP_IDX_CLKDIV, 8'h02);
    host.wr(`DKEXP_IDX_COARSE_HI, 8'h00);
    host.wr(`DKEXP_IDX_COARSE_LO, 8'h0A);
    host.wr(`DKEXP_IDX_FINE_HI, 8'h00);
    host.wr(`DKEXP_IDX_FINE_LO, 8'h14);
    frame();
    frame();
    chk(coarse_applied, 10);
    chk(exp_period_clk, (10 * 256 + 20) * 16);
    chk(fine_applied, 20);
    // With a total division of sixteen, 64 cycles hold exactly four enables.
    repeat (64) begin
      @(posedge clk);
      #1;
      n += pix_en;
    end
    chk(n, 4);
  endtask : t_exp

  // Black and dark sources are swapped to show they do not follow each other.
  task automatic t_ofs();
    host.wr(`DKEXP_IDX_DARK_SETUP, 8'h08);
    host.wr(`DKEXP_IDX_BLACK_SETUP, 8'h09);
    frame();
    chk(black_offset, 10'h05A);
    chk(dark_offset, 10'h000);
    pix_valid = 1'b1;
    pix_data = 10'h080;
    repeat (2) @(posedge clk);
    #1;
    chk(pix_out, 8'h40);
    pix_valid = 1'b0;
    host.wr(`DKEXP_IDX_DARK_SETUP, 8'h09);
    host.wr(`DKEXP_IDX_BLACK_SETUP, 8'h08);
    frame();
    chk(black_offset, 10'h000);
    chk(dark_offset, 10'h000);
  endtask : t_ofs

  // One line start, then a single pixel on that line.
  task automatic line_px(input logic dk, input logic [9:0] pd);
    ln_start = 1'b1;
    ln_dark = dk;
    @(posedge clk);
    #1;
    ln_start = 1'b0;
    pix_valid = 1'b1;
    pix_data = pd;
    @(posedge clk);
    #1;
    pix_valid = 1'b0;
  endtask : line_px

  // Half mode skips the edge line and every other one; used lines step the offset.
  task automatic t_dark();
    host.wr(`DKEXP_IDX_DARK_SETUP, 8'h05);
    frame();
    line_px(1'b1, 10'h090);
    chk(dark_offset, 10'h000);
    line_px(1'b1, 10'h090);
    chk(dark_offset, 10'h010);
    line_px(1'b1, 10'h0A0);
    chk(dark_offset, 10'h010);
    line_px(1'b1, 10'h0A0);
    chk(dark_offset, 10'h020);
  endtask : t_dark

  // Gain decode in every mode, both current-gain mappings, pending flag included.
  task automatic t_gain();
    logic [3:0] nib [4] = '{4'h0, 4'h4, 4'h6, 4'hC};
    logic [7:0] s;
    logic [3:0] ig;
    for (int vm = 0; vm < 4; vm++) begin
      for (int m = 0; m < 2; m++) begin
        host.wr(`DKEXP_IDX_SETUP0, 8'(vm));
        host.wr(`DKEXP_IDX_MODE_SEL, 8'(m << 1));
        foreach (nib[i]) begin
          host.wr(`DKEXP_IDX_GAIN, {4'hF, nib[i]});
          host.rd(`DKEXP_IDX_PRIMARY_STATUS_REG, s);
          chk(s[`DKEXP_ST_GAIN], 1'b1);
          frame();
          frame();
          host.rd(`DKEXP_IDX_PRIMARY_STATUS_REG, s);
          chk(s[`DKEXP_ST_GAIN], 1'b0);
          ig = (m == 1) ? ~nib[i] : ~{nib[i][0], nib[i][1], nib[i][2], nib[i][3]};
          chk(igain, ig);
          chk(cgain, (vm < 2) ? 6'h1F : 6'h3F);
          chk(adc_10bit, vm >= 2);
          chk(gain_q4, 256 / (ig + 1));
        end
      end
    end
  endtask : t_gain

  // A message in progress holds an armed gain back until the message ends.
  task automatic t_busy();
    logic [7:0] s;
    host.wr(`DKEXP_IDX_GAIN, 8'hF3);
    frame();
    busy = 1'b1;
    frame();
    host.rd(`DKEXP_IDX_PRIMARY_STATUS_REG, s);
    chk(s[`DKEXP_ST_GAIN], 1'b1);
    chk(igain, 4'h3);
    busy = 1'b0;
    frame();
    chk(igain, 4'hC);
  endtask : t_busy

  // A hang is cut short well past the expected run length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_rst();
    t_exp();
    t_ofs();
    t_dark();
    t_gain();
    t_busy();
    end_of_test();
  end
endmodule : dark_offset_exposure_gain_ctrl_tb
